// *** common/crb_pkg.sv ***
// Purpose: Shared constants for the charger rail and button register bank
// Assumes: 20 MHz reference clock, 8-bit registers
// Notes:   Button thresholds are held in milliseconds
package crb_pkg;

    // =========================================================
    // Register offsets and reset values
    localparam logic [7:0] DROOP_ADDR = 8'h18;
    localparam logic [7:0] ILIM_ADDR  = 8'h19;
    localparam logic [7:0] RAIL_ADDR  = 8'h1D;
    localparam logic [7:0] BTN_ADDR   = 8'h30;
    localparam logic [7:0] DROOP_RST  = 8'h3A;
    localparam logic [7:0] ILIM_RST   = 8'h01;
    localparam logic [7:0] RAIL_RST   = 8'h32;
    localparam logic [7:0] BTN_RST    = 8'h2E;

    // =========================================================
    // Field codes
    localparam logic [2:0] FOLD_OFF   = 3'h7;
    localparam logic [1:0] ACT_RESET  = 2'h0;

    // =========================================================
    // Timing, in their own units
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_W          = 14;
    localparam logic [13:0] MS_MAX     = 14'h3FFF;
    localparam logic [13:0] WAKE1_S_MS = 14'h007D;
    localparam logic [13:0] WAKE1_L_MS = 14'h01F4;
    localparam logic [13:0] WAKE2_S_MS = 14'h03E8;
    localparam logic [13:0] WAKE2_L_MS = 14'h07D0;

    // =========================================================
    // Decoding steps
    localparam logic [12:0] RAIL_BASE_MV  = 13'h0258;
    localparam logic [12:0] DROOP_BASE_MV = 13'h1068;
    localparam logic [12:0] STEP_100      = 13'h0064;
    localparam logic [12:0] FOLD_BASE_C   = 13'h0050;
    localparam logic [12:0] FOLD_STEP_C   = 13'h0005;

    // Base plus code times step
    function automatic logic [12:0] lin_val(input logic [12:0] base,
                                           input logic [12:0] step,
                                           input logic [4:0]  code);
        return 13'(base + step * {8'h00, code});
    endfunction

    // Input current limit in mA
    function automatic logic [9:0] ilim_ma(input logic [2:0] c);
        case (c)
            3'h0:    return 10'h032;
            3'h1:    return 10'h064;
            3'h2:    return 10'h096;
            3'h3:    return 10'h0C8;
            3'h4:    return 10'h12C;
            3'h5:    return 10'h190;
            3'h6:    return 10'h1F4;
            default: return 10'h258;
        endcase
    endfunction

    // Hardware-reset hold time in ms
    function automatic logic [13:0] hold_ms(input logic [1:0] c);
        case (c)
            2'h0:    return 14'h0FA0;
            2'h1:    return 14'h1F40;
            2'h2:    return 14'h2710;
            default: return 14'h36B0;
        endcase
    endfunction

    // Warning lead ahead of the hold time in ms
    function automatic logic [13:0] lead_ms(input logic [1:0] c);
        case (c)
            2'h0:    return 14'h01F4;
            2'h1:    return 14'h03E8;
            2'h2:    return 14'h05DC;
            default: return 14'h07D0;
        endcase
    endfunction

endpackage

// *** logic/crb_press_timer.sv ***
// Purpose: Measures a button press and raises threshold events
// Assumes: btn_low is already synchronised; tick is a 1 ms pulse
// Notes:   Events are one-cycle pulses, one per threshold per press
`timescale 1ns/1ps
module crb_press_timer (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       tick,
    input  wire logic       btn_low,
    input  wire logic       vin_ok,
    input  wire logic       gate,
    input  wire logic       wake1_sel,
    input  wire logic       wake2_sel,
    input  wire logic [1:0] warn_sel,
    input  wire logic [1:0] hold_sel,
    input  wire logic [1:0] action,
    output logic            wake1_evt,
    output logic            wake2_evt,
    output logic            warn_evt,
    output logic            hw_reset_evt,
    output logic            ship_evt
);
    import crb_pkg::*;

    // =========================================================
    // Press counter
    logic [MS_W-1:0] press_ff;   // Held time in ms
    logic [MS_W-1:0] nxt_press;  // Count after one more ms
    logic            step;       // A counted ms of press
    logic [MS_W-1:0] w1_ms;      // Selected thresholds
    logic [MS_W-1:0] w2_ms;
    logic [MS_W-1:0] hd_ms;
    logic [MS_W-1:0] wn_ms;
    logic            hold_hit;   // Hold time reached now

    // Thresholds follow the live settings
    always_comb begin
        step      = tick && btn_low && (press_ff != MS_MAX);
        nxt_press = press_ff + 14'h0001;
        w1_ms     = wake1_sel ? WAKE1_L_MS : WAKE1_S_MS;
        w2_ms     = wake2_sel ? WAKE2_L_MS : WAKE2_S_MS;
        hd_ms     = hold_ms(hold_sel);
        wn_ms     = hd_ms - lead_ms(warn_sel);
        hold_hit  = step && (nxt_press == hd_ms);
    end

    // Saturating count, cleared at once on release
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            press_ff <= '0;
        end else if (!btn_low) begin
            press_ff <= '0;
        end else if (step) begin
            press_ff <= nxt_press;
        end
    end

    // =========================================================
    // Events: equality on the step makes each fire once
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake1_evt    <= 1'b0;
            wake2_evt    <= 1'b0;
            warn_evt     <= 1'b0;
            hw_reset_evt <= 1'b0;
            ship_evt     <= 1'b0;
        end else begin
            wake1_evt    <= step && (nxt_press == w1_ms);
            wake2_evt    <= step && (nxt_press == w2_ms);
            warn_evt     <= step && (nxt_press == wn_ms);
            // Gate bit needs a valid supply at that very moment
            hw_reset_evt <= hold_hit && (action == ACT_RESET)
                            && (!gate || vin_ok);
            ship_evt     <= hold_hit && action[1];
        end
    end

    // =========================================================
    // Checks
    sequence s_hold_hit;
        step && (nxt_press == hd_ms);
    endsequence
    sequence s_free_reset;
        (action == ACT_RESET) && !gate;
    endsequence

    release_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !btn_low |=> press_ff == '0) else $error("count kept after release");
    wake1_point_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wake1_evt |-> press_ff == $past(w1_ms)) else $error("wake1 off point");
    wake2_point_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wake2_evt |-> press_ff == $past(w2_ms)) else $error("wake2 off point");
    warn_point_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        warn_evt |-> press_ff == $past(wn_ms)) else $error("warn off point");
    hold_point_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        hw_reset_evt || ship_evt |-> press_ff == $past(hd_ms))
        else $error("hold event off point");
    free_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (s_hold_hit and s_free_reset) |=> hw_reset_evt)
        else $error("ungated reset missing");
    gated_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_hold_hit ##0 (gate && !vin_ok) |=> !hw_reset_evt)
        else $error("reset without valid supply");
    event_once_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wake1_evt |=> !wake1_evt) else $error("wake1 repeated");

endmodule

// *** logic/crb_regs_top.sv ***
// Purpose: Two-wire register slice for input, rail and button control
// Assumes: 20 MHz ref_clk far above the serial clock rate
// Notes:   Decoded values are registered; no clock stretching
//
// Notes on behaviour
// - droop regulation on when bit low
// - foldback 80 to 110 C, code 7 off
// - current limit codes ascend, reset 100 mA
// - rail voltage 600 mV plus 100 mV steps
// - rail enable bit, resets off
// - mode bit: regulator or switch, resets switch
// - gate low: reset when hold reached
// - gate high: reset needs valid supply too
// - first wake 125 or 500 ms
// - second wake 1 or 2 s
// - hold time 4, 8, 10, 14 s
// - warning 0.5 to 2 s before hold
// - current limit register 0x19, reset 0x1
// - rail register 0x1D, reset 0x32
// - button timing register 0x30, reset 0x2E
// - long press action picks reset, nothing, ship
`timescale 1ns/1ps
module crb_regs_top #(
    parameter int unsigned ms_cycles_p = crb_pkg::MS_CYCLES,
    // Arbitrary bus address value
    parameter logic [6:0]  dev_addr_p  = 7'h2A
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        scl,
    input  wire logic        sda,
    output logic             sda_data,
    output logic             sda_oe,
    input  wire logic        pushbutton_input_n,
    input  wire logic        vin_valid,
    input  wire logic [1:0]  button_long_press_action,
    output logic             input_droop_disable,
    output logic [2:0]       input_droop_level,
    output logic [2:0]       thermal_foldback_threshold,
    output logic [2:0]       input_current_limit,
    output logic             output_rail_enable,
    output logic [4:0]       rail_voltage_code,
    output logic             rail_mode_select,
    output logic [12:0]      droop_mv,
    output logic [12:0]      foldback_c,
    output logic             foldback_on,
    output logic [9:0]       ilim_ma,
    output logic [12:0]      rail_mv,
    output logic             button_wake1_evt,
    output logic             button_wake2_evt,
    output logic             button_warn_evt,
    output logic             button_hw_reset,
    output logic             button_ship_req
);
    import crb_pkg::*;

    // =========================================================
    // Serial engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK  = 3'b010,
        ST_WR   = 3'b011,
        ST_RD   = 3'b100,
        ST_RACK = 3'b101
    } crb_st_t;

    localparam int TW = $clog2(ms_cycles_p + 1);

    // =========================================================
    // Storage
    logic [7:0]  droop_ff;   // Droop and foldback control
    logic [7:0]  ilim_ff;    // Input current limit control
    logic [7:0]  rail_ff;    // Output rail control
    logic [7:0]  btn_ff;     // Button timing control
    crb_st_t     st_ff;      // Serial engine state
    logic [3:0]  cnt_ff;     // Bits seen in this byte
    logic [7:0]  sh_ff;      // Shift register
    logic [7:0]  ptr_ff;     // Register pointer
    logic        ptr_ok_ff;  // Pointer byte already taken
    logic        rw_ff;      // Read transfer
    logic        oe_ff;      // Pull the data line low
    logic [2:0]  scl_ff;     // Sync pair plus history
    logic [2:0]  sda_ff;
    logic [1:0]  btn_s_ff;   // Button sync pair
    logic [1:0]  vin_s_ff;   // Supply-valid sync pair
    logic [TW-1:0] tick_cnt_ff;  // Millisecond divider
    logic        tick_ff;    // One-cycle ms pulse
    logic        up_ff;      // Low only in first cycle after reset

    // =========================================================
    // Line events, seen only after the sync pair
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic wr_stb;      // Store one data byte
    logic [7:0] rdat;  // Register at the pointer

    always_comb begin
        scl_rise = scl_ff[1] && !scl_ff[2];
        scl_fall = !scl_ff[1] && scl_ff[2];
        start_c  = scl_ff[1] && scl_ff[2] && sda_ff[2] && !sda_ff[1];
        stop_c   = scl_ff[1] && scl_ff[2] && !sda_ff[2] && sda_ff[1];
        wr_stb   = scl_fall && (st_ff == ST_WR) && (cnt_ff == 4'h8)
                   && ptr_ok_ff;
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (ptr_ff)
            DROOP_ADDR: rdat = droop_ff;
            ILIM_ADDR:  rdat = ilim_ff;
            RAIL_ADDR:  rdat = rail_ff;
            BTN_ADDR:   rdat = btn_ff;
            default:    rdat = 8'h00;
        endcase
    end

    // =========================================================
    // Synchronisers: the first stage feeds only the second
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_ff   <= 3'h7;
            sda_ff   <= 3'h7;
            btn_s_ff <= 2'h3;
            vin_s_ff <= 2'h0;
        end else begin
            scl_ff   <= {scl_ff[1:0], scl};
            sda_ff   <= {sda_ff[1:0], sda};
            btn_s_ff <= {btn_s_ff[0], pushbutton_input_n};
            vin_s_ff <= {vin_s_ff[0], vin_valid};
        end
    end

    // =========================================================
    // Serial engine
    // Data changes only after a clock fall, keeping hold time
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff     <= ST_IDLE;
            cnt_ff    <= 4'h0;
            sh_ff     <= 8'h00;
            ptr_ff    <= 8'h00;
            ptr_ok_ff <= 1'b0;
            rw_ff     <= 1'b0;
            oe_ff     <= 1'b0;
        end else if (start_c) begin
            // Start or repeated start; pointer is kept for reads
            st_ff     <= ST_ADDR;
            cnt_ff    <= 4'h0;
            ptr_ok_ff <= 1'b0;
            oe_ff     <= 1'b0;
        end else if (stop_c) begin
            st_ff <= ST_IDLE;
            oe_ff <= 1'b0;
        end else begin
            unique case (st_ff)
                ST_IDLE: begin
                    oe_ff <= 1'b0;
                end
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        sh_ff  <= {sh_ff[6:0], sda_ff[1]};
                        cnt_ff <= cnt_ff + 4'h1;
                    end else if (scl_fall && cnt_ff == 4'h8) begin
                        cnt_ff <= 4'h0;
                        if (st_ff == ST_WR) begin
                            // Acknowledge every written byte
                            oe_ff <= 1'b1;
                            st_ff <= ST_ACK;
                            if (!ptr_ok_ff) begin
                                ptr_ff    <= sh_ff;
                                ptr_ok_ff <= 1'b1;
                            end else begin
                                ptr_ff <= ptr_ff + 8'h01;
                            end
                        end else if (sh_ff[7:1] == dev_addr_p) begin
                            oe_ff <= 1'b1;
                            rw_ff <= sh_ff[0];
                            st_ff <= ST_ACK;
                        end else begin
                            // Other device: stay quiet
                            st_ff <= ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        cnt_ff <= 4'h0;
                        if (rw_ff) begin
                            sh_ff  <= rdat;
                            oe_ff  <= !rdat[7];
                            ptr_ff <= ptr_ff + 8'h01;
                            st_ff  <= ST_RD;
                        end else begin
                            oe_ff <= 1'b0;
                            st_ff <= ST_WR;
                        end
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_ff == 4'h8) begin
                            // Release for the controller's ack
                            oe_ff <= 1'b0;
                            st_ff <= ST_RACK;
                        end else begin
                            sh_ff <= {sh_ff[6:0], 1'b0};
                            oe_ff <= !sh_ff[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise && sda_ff[1]) begin
                        // Not acknowledged: read ends
                        st_ff <= ST_IDLE;
                    end else if (scl_fall) begin
                        // Acknowledged: next byte, pointer advances
                        cnt_ff <= 4'h0;
                        sh_ff  <= rdat;
                        oe_ff  <= !rdat[7];
                        ptr_ff <= ptr_ff + 8'h01;
                        st_ff  <= ST_RD;
                    end
                end
                default: begin
                    st_ff <= ST_IDLE;
                    oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // =========================================================
    // Register file; all bits, reserved ones too, are writable
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            droop_ff <= DROOP_RST;
            ilim_ff  <= ILIM_RST;
            rail_ff  <= RAIL_RST;
            btn_ff   <= BTN_RST;
        end else if (wr_stb) begin
            case (ptr_ff)
                DROOP_ADDR: droop_ff <= sh_ff;
                ILIM_ADDR:  ilim_ff  <= sh_ff;
                RAIL_ADDR:  rail_ff  <= sh_ff;
                BTN_ADDR:   btn_ff   <= sh_ff;
                default:    droop_ff <= droop_ff;
            endcase
        end
    end

    // Open-drain line: only ever pulls low
    always_comb begin
        sda_data = 1'b0;
        sda_oe   = oe_ff;
    end

    // Control fields straight from the register bits
    always_comb begin
        input_droop_disable        = droop_ff[7];
        input_droop_level          = droop_ff[6:4];
        thermal_foldback_threshold = droop_ff[2:0];
        input_current_limit        = ilim_ff[2:0];
        output_rail_enable         = rail_ff[7];
        rail_voltage_code          = rail_ff[6:2];
        rail_mode_select           = rail_ff[1];
    end

    // =========================================================
    // Decoded set points for the analog loops
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            droop_mv    <= 13'h0000;
            foldback_c  <= 13'h0000;
            foldback_on <= 1'b0;
            ilim_ma     <= 10'h000;
            rail_mv     <= 13'h0000;
        end else begin
            droop_mv    <= lin_val(DROOP_BASE_MV, STEP_100,
                                   {2'h0, droop_ff[6:4]});
            foldback_c  <= lin_val(FOLD_BASE_C, FOLD_STEP_C,
                                   {2'h0, droop_ff[2:0]});
            foldback_on <= droop_ff[2:0] != FOLD_OFF;
            ilim_ma     <= crb_pkg::ilim_ma(ilim_ff[2:0]);
            rail_mv     <= lin_val(RAIL_BASE_MV, STEP_100,
                                   rail_ff[6:2]);
        end
    end

    // =========================================================
    // Millisecond enable; one clock, no derived clock
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_ff <= '0;
            tick_ff     <= 1'b0;
        end else if (tick_cnt_ff == TW'(ms_cycles_p - 1)) begin
            tick_cnt_ff <= '0;
            tick_ff     <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + TW'(1);
            tick_ff     <= 1'b0;
        end
    end

    // Marks the first cycle after reset for checking
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            up_ff <= 1'b0;
        end else begin
            up_ff <= 1'b1;
        end
    end

    // =========================================================
    // Press timing
    crb_press_timer u_press (
        .ref_clk      (ref_clk),
        .rst_b        (rst_b),
        .tick         (tick_ff),
        .btn_low      (!btn_s_ff[1]),
        .vin_ok       (vin_s_ff[1]),
        .gate         (btn_ff[7]),
        .wake1_sel    (btn_ff[6]),
        .wake2_sel    (btn_ff[5]),
        .warn_sel     (btn_ff[4:3]),
        .hold_sel     (btn_ff[2:1]),
        .action       (button_long_press_action),
        .wake1_evt    (button_wake1_evt),
        .wake2_evt    (button_wake2_evt),
        .warn_evt     (button_warn_evt),
        .hw_reset_evt (button_hw_reset),
        .ship_evt     (button_ship_req)
    );

    // =========================================================
    // Checks
    reset_values_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !up_ff |-> ilim_ff == ILIM_RST && rail_ff == RAIL_RST
                   && btn_ff == BTN_RST) else $error("bad reset value");
    rail_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_stb && ptr_ff == RAIL_ADDR |=> rail_ff == $past(sh_ff))
        else $error("rail write lost");
    btn_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_stb && ptr_ff == BTN_ADDR |=> btn_ff == $past(sh_ff))
        else $error("button write lost");
    rail_volts_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        up_ff |=> rail_mv == 13'h0258 + 13'h0064 * {8'h00, $past(rail_ff[6:2])})
        else $error("rail voltage mismatch");

endmodule

// *** verif/crb_host.sv ***
// Purpose: Host model that drives the two-wire register bus
// Assumes: Data line pulled up; the device only pulls it low
// Notes:   Bit phases are 8 ref_clk cycles; no clock stretching
`timescale 1ns/1ps
module crb_host #(
    parameter logic [6:0] addr_p = 7'h2A
) (
    input  wire logic ref_clk,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    logic drv_low = 1'b0; // Host pulls data low
    initial scl = 1'b1;
    // Wired-and with the pull-up
    assign sda = !(drv_low || sda_oe);
    task automatic half;
        repeat (8) @(posedge ref_clk);
        #5;
    endtask
    // Start or repeated start; data is released while the clock is low, then pulled low while the clock is high
    task automatic go;
        drv_low = 0; half(); scl = 1; half(); drv_low = 1; half();
        scl = 0; half();
    endtask
    task automatic sp;
        drv_low = 1; half(); scl = 1; half(); drv_low = 0; half();
    endtask
    // One byte MSB first, then the ninth bit left released
    task automatic xb(input logic [7:0] d, output logic [7:0] q,
                      output logic a);
        for (int i = 7; i >= 0; i--) begin
            drv_low = !d[i]; half(); scl = 1; half(); q[i] = sda;
            scl = 0; half();
        end
        drv_low = 0; half(); scl = 1; half(); a = sda; scl = 0; half();
    endtask
    task automatic wr(input logic [6:0] da, input logic [7:0] p, d,
                      output logic a);
        logic [7:0] q;
        logic k;
        go(); xb({da, 1'b0}, q, a); xb(p, q, k); xb(d, q, k); sp();
    endtask
    // Single byte read, closed by a not-acknowledge
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic k;
        go(); xb({addr_p, 1'b0}, d, k); xb(p, d, k); go();
        xb({addr_p, 1'b1}, d, k); xb(8'hFF, d, k); sp();
    endtask
endmodule

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the register and button slice
// Assumes: crb_host drives the bus; short ms tick for the button
// Notes:   Event times are checked from under one tick early to six cycles late
`timescale 1ns/1ps
module tb_top;
    import crb_pkg::*;
    localparam int M = 4; // Cycles per ms tick
    logic ref_clk = 0, rst_b = 0, oe, btn_n = 1, vin = 0, ack, en, mode;
    logic fon, ddis;
    wire scl, sda;
    logic [1:0] act = 0;
    wire [4:0] evt;
    logic [2:0] idl, tft, ilc;
    logic [4:0] rvc;
    logic [7:0] rv;
    logic [12:0] dmv, fc, rmv;
    logic [9:0] ima;
    int fails = 0, compares = 0, cyc = 0, p0, at[5], cnt[5];
    int ma[8] = '{50, 100, 150, 200, 300, 400, 500, 600};
    crb_regs_top #(.ms_cycles_p(M)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .scl(scl), .sda(sda), .sda_data(), .sda_oe(oe),
        .pushbutton_input_n(btn_n), .vin_valid(vin),
        .button_long_press_action(act), .input_droop_disable(ddis),
        .input_droop_level(idl), .thermal_foldback_threshold(tft),
        .input_current_limit(ilc), .output_rail_enable(en),
        .rail_voltage_code(rvc), .rail_mode_select(mode), .droop_mv(dmv),
        .foldback_c(fc), .foldback_on(fon), .ilim_ma(ima), .rail_mv(rmv),
        .button_wake1_evt(evt[0]), .button_wake2_evt(evt[1]),
        .button_warn_evt(evt[2]), .button_hw_reset(evt[3]),
        .button_ship_req(evt[4]));
    crb_host host (.ref_clk(ref_clk), .sda_oe(oe), .scl(scl), .sda(sda));
    initial forever #25 ref_clk = ~ref_clk;
    // Log when and how often each button event fires
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 5; i++) if (evt[i] === 1'b1) begin
            at[i] <= cyc;
            cnt[i] <= cnt[i] + 1;
        end
    end
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(logic [7:0] p, logic [7:0] e);
        host.rd(p, rv);
        chk("reg", {8'h00, rv}, {8'h00, e});
    endtask
    // Fired once, from under a tick before the threshold to six cycles after
    task automatic tm(string n, int i, int ms);
        chk(n, 16'(at[i] - p0 >= ms * M - M + 1 && at[i] - p0 <= ms * M + 6
            && cnt[i] == 1), 16'h0001);
    endtask
    // Hold the button past the 4 s hold time
    task automatic press(logic [7:0] cfg, logic v, logic [1:0] a,
                         int w1, int w2, int wn);
        host.wr(7'h2A, BTN_ADDR, cfg, ack);
        vin = v; act = a; at = '{default: 0}; cnt = '{default: 0};
        repeat (4) @(posedge ref_clk);
        #5 p0 = cyc; btn_n = 0;
        repeat (4000 * M + 30) @(posedge ref_clk);
        #5 btn_n = 1;
        tm("wake1", 0, w1);
        tm("wake2", 1, w2);
        tm("warn", 2, wn);
    endtask
    task automatic test_done;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        #5 rst_b = 1;
        repeat (3) @(posedge ref_clk);
        #5;
        rchk(ILIM_ADDR, 8'h01);
        rchk(RAIL_ADDR, 8'h32);
        rchk(BTN_ADDR, 8'h2E);
        chk("rail_mv", rmv, 16'd1800);
        chk("rail_code", rvc, 16'd12);
        chk("ilim_code", ilc, 16'd1);
        chk("ilim_ma", ima, 16'd100);
        chk("rail_on", en, 16'd0);
        chk("mode", mode, 16'd1);
        host.wr(7'h2A, RAIL_ADDR, 8'hFC, ack);
        chk("rail_mv", rmv, 16'd3700);
        chk("rail_code", rvc, 16'd31);
        chk("rail_on", en, 16'd1);
        chk("mode", mode, 16'd0);
        // Foreign address: no acknowledge, register untouched
        host.wr(7'h2B, RAIL_ADDR, 8'h00, ack);
        chk("nack", ack, 16'd1);
        rchk(RAIL_ADDR, 8'hFC);
        for (int c = 0; c < 8; c++) begin
            host.wr(7'h2A, ILIM_ADDR, 8'(c), ack);
            chk("ilim_ma", ima, 16'(ma[c]));
            chk("ilim_code", ilc, 16'(c));
        end
        host.wr(7'h2A, DROOP_ADDR, 8'hF7, ack);
        chk("droop_mv", dmv, 16'd4900);
        chk("droop_off", ddis, 16'd1);
        chk("droop_lvl", idl, 16'd7);
        chk("fold_on", fon, 16'd0);
        host.wr(7'h2A, DROOP_ADDR, 8'h06, ack);
        chk("droop_mv", dmv, 16'd4200);
        chk("fold_c", fc, 16'd110);
        chk("fold_code", tft, 16'd6);
        press(8'h58, 1'b0, 2'b00, 500, 1000, 2000);
        tm("hold", 3, 4000);
        chk("ship", 16'(cnt[4]), 16'd0);
        press(8'hA0, 1'b0, 2'b00, 125, 2000, 3500);
        chk("gated", 16'(cnt[3]), 16'd0);
        press(8'hA0, 1'b1, 2'b10, 125, 2000, 3500);
        tm("ship", 4, 4000);
        chk("hw_reset", 16'(cnt[3]), 16'd0);
        press(8'hA0, 1'b1, 2'b00, 125, 2000, 3500);
        tm("gated_rst", 3, 4000);
        test_done();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        test_done();
    end
endmodule
